/* File: design/uart_sc_pkg.sv */
// Purpose: shared constants, types and helpers of the serial status block
// Assumes: 10 MHz clock, fixed bit rate
// Notes: register map sits on a 32-bit classic wishbone slave
package uart_sc_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int BIT_TIME_NS = 104167;
   localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam logic [11:0] BIT_CNT_MAX = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALF_BIT_MAX = 12'(BIT_CYCLES / 2 - 1);
   // register byte offsets
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_TX_DATA = 4'h4;
   localparam logic [3:0] OFS_RX_DATA = 4'h8;
   localparam logic [3:0] OFS_MODE = 4'hc;
   // status and control field positions
   localparam int BIT_TXSEL1 = 15;
   localparam int BIT_TX_POL = 14;
   localparam int BIT_TXSEL0 = 13;
   localparam int BIT_TX_BRK = 11;
   localparam int BIT_TX_EN = 10;
   localparam int BIT_TX_FULL = 9;
   localparam int BIT_TX_EMPTY = 8;
   localparam int BIT_RXSEL = 6;
   localparam int BIT_ADDR_EN = 5;
   localparam int BIT_RX_IDLE = 4;
   localparam int BIT_PARITY_ERROR_FLAG = 3;
   localparam int BIT_FRAMING_ERROR_FLAG = 2;
   localparam int BIT_OVERRUN_ERROR_FLAG = 1;
   localparam int BIT_RX_AVAIL = 0;
   // mode register field positions
   localparam int BIT_FMT = 0;
   localparam int BIT_IR_EN = 3;
   // reset values and sizes
   localparam logic [1:0] RX_MODE_RESET = 2'b00;
   localparam logic [2:0] FIFO_DEPTH = 3'h4;
   localparam logic [2:0] RX_LEVEL_3Q = 3'h3;
   localparam int BREAK_ZEROS = 12;
   localparam logic [3:0] FRAME_BITS_8N = 4'ha;
   localparam logic [3:0] FRAME_BITS_LONG = 4'hb;
   localparam logic [3:0] FRAME_BITS_BREAK = 4'he;
   localparam logic [3:0] RX_BITS_8N = 4'h9;
   localparam logic [3:0] RX_BITS_LONG = 4'ha;

   typedef enum logic [1:0] {
      TXI_EACH = 2'b00,
      TXI_DONE = 2'b01,
      TXI_EMPTY = 2'b10,
      TXI_RSVD = 2'b11
   } tx_irq_mode_t;

   typedef enum logic [1:0] {
      FMT_8N = 2'b00,
      FMT_8E = 2'b01,
      FMT_8O = 2'b10,
      FMT_9N = 2'b11
   } fmt_t;

   typedef struct packed {
      logic framing_error_flag;
      logic parity_error_flag;
      logic [8:0] data;
   } rx_char_t;

   // parity bit of a byte, even or odd sense
   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction
endpackage

/* File: design/serial_tx_shift.sv */
// Purpose: transmit shift register, one frame per load
// Assumes: caller loads only while idle
// Notes: line output is raw, idle high
`timescale 1ns/1ps
`default_nettype none
module serial_tx_shift
   import uart_sc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic abort_i,
   input wire logic load_i,
   input wire logic brk_i,
   input wire logic [8:0] data_i,
   input wire fmt_t fmt_i,
   output logic busy_o,
   output logic done_o,
   output logic line_o
);
   logic [13:0] frame;
   logic [3:0] bits_left;
   logic [11:0] tick;
   logic [13:0] next_frame;
   logic [3:0] next_bits;

   // frame image for the next load, lsb first
   always_comb begin
      next_frame = {5'h1f, data_i[7:0], 1'b0};
      next_bits = FRAME_BITS_8N;
      if (brk_i) begin
         next_frame = {1'b1, {BREAK_ZEROS{1'b0}}, 1'b0};
         next_bits = FRAME_BITS_BREAK;
      end else if (fmt_i == FMT_9N) begin
         next_frame = {4'hf, data_i, 1'b0};
         next_bits = FRAME_BITS_LONG;
      end else if (fmt_i != FMT_8N) begin
         next_frame = {4'hf, parity_of(data_i[7:0], fmt_i == FMT_8O), data_i[7:0], 1'b0};
         next_bits = FRAME_BITS_LONG;
      end
   end

   // bit timing and shifting; abort drops the frame at once
   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i) begin
         frame <= '1;
         bits_left <= '0;
         tick <= '0;
         busy_o <= 1'b0;
      end else if (load_i && !busy_o) begin
         frame <= next_frame;
         bits_left <= next_bits;
         tick <= '0;
         busy_o <= 1'b1;
      end else if (busy_o) begin
         if (tick == BIT_CNT_MAX) begin
            tick <= '0;
            frame <= {1'b1, frame[13:1]};
            bits_left <= bits_left - 4'h1;
            busy_o <= (bits_left != 4'h1);
         end else begin
            tick <= tick + 12'h001;
         end
      end
   end

   // one-cycle pulse once the stop bit has gone out
   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= busy_o && tick == BIT_CNT_MAX && bits_left == 4'h1;
      end
   end

   assign line_o = frame[0];
endmodule
`default_nettype wire

/* File: design/serial_rx_shift.sv */
// Purpose: receive shift register with start check and mid-bit sampling
// Assumes: line idles high and is synchronous to clk_i
// Notes: emits one character pulse per frame
`timescale 1ns/1ps
`default_nettype none
module serial_rx_shift
   import uart_sc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic abort_i,
   input wire logic line_i,
   input wire fmt_t fmt_i,
   output logic valid_o,
   output rx_char_t char_o,
   output logic idle_o
);
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b10
   } rx_state_t;

   rx_state_t state;
   logic [11:0] tick;
   logic [3:0] cnt;
   logic [9:0] sh;
   logic [9:0] next_sh;
   logic [3:0] last_bit;
   rx_char_t next_char;

   // decode of the frame once its last bit lands at sh[9]
   always_comb begin
      next_sh = {line_i, sh[9:1]};
      last_bit = (fmt_i == FMT_8N) ? RX_BITS_8N - 4'h1 : RX_BITS_LONG - 4'h1;
      next_char.framing_error_flag = !line_i;
      next_char.parity_error_flag = 1'b0;
      next_char.data = {1'b0, next_sh[7:0]};
      if (fmt_i == FMT_8N) begin
         next_char.data = {1'b0, next_sh[8:1]};
      end else if (fmt_i == FMT_9N) begin
         next_char.data = next_sh[8:0];
      end else begin
         next_char.parity_error_flag = next_sh[8] != parity_of(next_sh[7:0], fmt_i == FMT_8O);
      end
   end

   // receive sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i) begin
         state <= RX_IDLE;
         tick <= '0;
         cnt <= '0;
         sh <= '0;
         valid_o <= 1'b0;
         char_o <= '0;
      end else begin
         valid_o <= 1'b0;
         unique case (state)
            RX_IDLE: begin
               tick <= '0;
               if (!line_i) begin
                  state <= RX_START;
               end
            end
            RX_START: begin
               if (tick == HALF_BIT_MAX) begin
                  tick <= '0;
                  cnt <= '0;
                  state <= line_i ? RX_IDLE : RX_BITS;
               end else begin
                  tick <= tick + 12'h001;
               end
            end
            RX_BITS: begin
               if (tick == BIT_CNT_MAX) begin
                  tick <= '0;
                  sh <= next_sh;
                  cnt <= cnt + 4'h1;
                  if (cnt == last_bit) begin
                     state <= RX_IDLE;
                     valid_o <= 1'b1;
                     char_o <= next_char;
                  end
               end else begin
                  tick <= tick + 12'h001;
               end
            end
            default: state <= RX_IDLE;
         endcase
      end
   end

   assign idle_o = (state == RX_IDLE);
endmodule
`default_nettype wire

/* File: design/uart_status_control.sv */
// Purpose: status and control register of a serial port with tx/rx queues
// Assumes: classic wishbone master, one clock, synchronous reset
// Notes: interrupts are one-cycle pulses for an outside controller
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uart_status_control
   import uart_sc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic serial_rx_i,
   output logic serial_tx_o,
   output logic serial_tx_oe_o,
   output logic tx_irq_o,
   output logic rx_irq_o
);
   // queue level after a push and a pop
   function automatic logic [2:0] next_level(input logic [2:0] c, input logic in, input logic out);
      return c + {2'b00, in} - {2'b00, out};
   endfunction
   logic req, wr_stb, rd_stb, wr_hi, wr_lo, wr_mode;
   tx_irq_mode_t tx_irq_mode_sel;
   logic tx_idle_polarity, tx_break_request, tx_enable_bit, en_q, en_rise;
   logic [1:0] rx_irq_mode_sel;
   logic address_detect_enable, overrun_error_flag, infrared_codec_enable;
   fmt_t data_fmt;
   logic [8:0] tx_mem [4];
   logic [1:0] tx_wp, tx_rp;
   logic [2:0] tx_count;
   logic tx_push, tx_load, tx_flush, tx_busy, tx_done, tx_line, brk_active;
   logic tx_buffer_full_flag, tx_shift_empty_flag;
   rx_char_t rx_mem [4];
   rx_char_t rx_char, rx_head;
   logic [1:0] rx_wp, rx_rp;
   logic [2:0] rx_count, rx_next;
   logic rx_valid, receiver_idle_flag, rx_accept, rx_take, rx_push, rx_pop;
   logic ovr_set, ovr_clear, rx_flush;
   logic [15:0] status_word;
   logic [31:0] read_word;
   //--------------------------------------------------------------
   // wishbone slave
   //--------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_stb = req && wb_ack_o && wb_we_i;
   assign rd_stb = req && wb_ack_o && !wb_we_i;
   assign wr_hi = wr_stb && wb_adr_i == OFS_STATUS && wb_sel_i[1];
   assign wr_lo = wr_stb && wb_adr_i == OFS_STATUS && wb_sel_i[0];
   assign wr_mode = wr_stb && wb_adr_i == OFS_MODE && wb_sel_i[0];
   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
      end
   end
   // status word assembly
   always_comb begin
      status_word = '0;
      status_word[BIT_TXSEL1] = tx_irq_mode_sel[1];
      status_word[BIT_TX_POL] = tx_idle_polarity;
      status_word[BIT_TXSEL0] = tx_irq_mode_sel[0];
      status_word[BIT_TX_BRK] = tx_break_request;
      status_word[BIT_TX_EN] = tx_enable_bit;
      status_word[BIT_TX_FULL] = tx_buffer_full_flag;
      status_word[BIT_TX_EMPTY] = tx_shift_empty_flag;
      status_word[BIT_RXSEL +: 2] = rx_irq_mode_sel;
      status_word[BIT_ADDR_EN] = address_detect_enable;
      status_word[BIT_RX_IDLE] = receiver_idle_flag;
      status_word[BIT_PARITY_ERROR_FLAG] = rx_count != 3'h0 && rx_head.parity_error_flag;
      status_word[BIT_FRAMING_ERROR_FLAG] = rx_count != 3'h0 && rx_head.framing_error_flag;
      status_word[BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag;
      status_word[BIT_RX_AVAIL] = rx_count != 3'h0;
   end
   // read decode, unmapped offsets read zero
   always_comb begin
      read_word = '0;
      unique case (wb_adr_i)
         OFS_STATUS: read_word[15:0] = status_word;
         OFS_RX_DATA: read_word[8:0] = rx_count != 3'h0 ? rx_head.data : 9'h000;
         OFS_MODE: begin
            read_word[BIT_FMT +: 2] = data_fmt;
            read_word[BIT_IR_EN] = infrared_codec_enable;
         end
         default: read_word = '0;
      endcase
   end
   // read data captured while the request waits for ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (req && !wb_ack_o) begin
         wb_dat_o <= read_word;
      end
   end

   //--------------------------------------------------------------
   // control fields
   //--------------------------------------------------------------
   // transmit controls; hardware clears break after its frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_irq_mode_sel <= TXI_EACH;
         tx_idle_polarity <= 1'b0;
         tx_break_request <= 1'b0;
         tx_enable_bit <= 1'b0;
      end else begin
         if (tx_done && brk_active) begin
            tx_break_request <= 1'b0;
         end
         if (wr_hi) begin
            tx_irq_mode_sel <= tx_irq_mode_t'({wb_dat_i[BIT_TXSEL1], wb_dat_i[BIT_TXSEL0]});
            tx_idle_polarity <= wb_dat_i[BIT_TX_POL];
            tx_break_request <= wb_dat_i[BIT_TX_BRK];
            tx_enable_bit <= wb_dat_i[BIT_TX_EN];
         end
      end
   end
   // receive controls and mode register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_irq_mode_sel <= RX_MODE_RESET;
         address_detect_enable <= 1'b0;
         data_fmt <= FMT_8N;
         infrared_codec_enable <= 1'b0;
      end else begin
         if (wr_lo) begin
            rx_irq_mode_sel <= wb_dat_i[BIT_RXSEL +: 2];
            address_detect_enable <= wb_dat_i[BIT_ADDR_EN];
         end
         if (wr_mode) begin
            data_fmt <= fmt_t'(wb_dat_i[BIT_FMT +: 2]);
            infrared_codec_enable <= wb_dat_i[BIT_IR_EN];
         end
      end
   end

   //--------------------------------------------------------------
   // transmit queue and shifter
   //--------------------------------------------------------------
   assign tx_buffer_full_flag = tx_count == FIFO_DEPTH;
   assign tx_shift_empty_flag = !tx_busy && tx_count == 3'h0;
   assign tx_push = wr_stb && wb_adr_i == OFS_TX_DATA && wb_sel_i[0] && !tx_buffer_full_flag;
   assign tx_load = tx_enable_bit && !tx_busy && tx_count != 3'h0;
   assign tx_flush = !tx_enable_bit && en_q;
   // four-entry queue, flushed on the disabling edge
   always_ff @(posedge clk_i) begin
      if (rst_i || tx_flush) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_count <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp] <= wb_dat_i[8:0];
            tx_wp <= tx_wp + 2'h1;
         end
         if (tx_load) begin
            tx_rp <= tx_rp + 2'h1;
         end
         tx_count <= next_level(tx_count, tx_push, tx_load);
      end
   end
   // a pending break replaces the dummy char; a load as the break ends sends data
   always_ff @(posedge clk_i) begin
      if (rst_i || !tx_enable_bit) begin
         brk_active <= 1'b0;
      end else if (tx_load) begin
         brk_active <= tx_break_request && !(tx_done && brk_active);
      end else if (tx_done) begin
         brk_active <= 1'b0;
      end
   end
   serial_tx_shift u_tx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .abort_i(!tx_enable_bit),
      .load_i(tx_load),
      .brk_i(tx_break_request && !(tx_done && brk_active)),
      .data_i(tx_mem[tx_rp]),
      .fmt_i(data_fmt),
      .busy_o(tx_busy),
      .done_o(tx_done),
      .line_o(tx_line)
   );
   // pin level and pin ownership
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_tx_o <= 1'b1;
         serial_tx_oe_o <= 1'b0;
      end else begin
         serial_tx_o <= tx_line ^ tx_idle_polarity ^ infrared_codec_enable;
         serial_tx_oe_o <= tx_enable_bit;
      end
   end
   // transmit interrupt sources
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         en_rise <= 1'b0;
         tx_irq_o <= 1'b0;
      end else begin
         en_q <= tx_enable_bit;
         en_rise <= tx_enable_bit && !en_q;
         tx_irq_o <= en_rise
            || (tx_load && tx_irq_mode_sel == TXI_EACH)
            || (tx_done && tx_count == 3'h0 && !tx_push && tx_irq_mode_sel == TXI_DONE)
            || (tx_load && tx_count == 3'h1 && !tx_push && tx_irq_mode_sel == TXI_EMPTY);
      end
   end

   //--------------------------------------------------------------
   // receive shifter and queue
   //--------------------------------------------------------------
   serial_rx_shift u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .abort_i(rx_flush),
      .line_i(serial_rx_i),
      .fmt_i(data_fmt),
      .valid_o(rx_valid),
      .char_o(rx_char),
      .idle_o(receiver_idle_flag)
   );
   assign rx_accept = !(address_detect_enable && data_fmt == FMT_9N && !rx_char.data[8]);
   assign rx_take = rx_valid && rx_accept && !overrun_error_flag;
   assign rx_push = rx_take && rx_count != FIFO_DEPTH;
   assign ovr_set = rx_take && rx_count == FIFO_DEPTH;
   assign rx_pop = rd_stb && wb_adr_i == OFS_RX_DATA && rx_count != 3'h0;
   assign ovr_clear = wr_lo && !wb_dat_i[BIT_OVERRUN_ERROR_FLAG] && overrun_error_flag;
   assign rx_flush = ovr_clear && !ovr_set;
   assign rx_next = next_level(rx_count, rx_push, rx_pop);
   assign rx_head = rx_mem[rx_rp];
   // four-entry queue with error bits per character
   always_ff @(posedge clk_i) begin
      if (rst_i || rx_flush) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_count <= '0;
      end else begin
         if (rx_push) begin
            rx_mem[rx_wp] <= rx_char;
            rx_wp <= rx_wp + 2'h1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 2'h1;
         end
         rx_count <= rx_next;
      end
   end
   // overrun flag, a new overflow beats a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overrun_error_flag <= 1'b0;
      end else begin
         overrun_error_flag <= ovr_set || (overrun_error_flag && !ovr_clear);
      end
   end
   // receive interrupt on every push, or in modes 10 and 11 on the level reached by a push
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_irq_o <= 1'b0;
      end else begin
         rx_irq_o <= rx_push && (!rx_irq_mode_sel[1]
            || (rx_irq_mode_sel[0] && rx_next == FIFO_DEPTH)
            || (!rx_irq_mode_sel[0] && rx_next == RX_LEVEL_3Q));
      end
   end

   //--------------------------------------------------------------
   // assertions
   //--------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence seq_en_rise;
      tx_enable_bit && !en_q;
   endsequence
   sequence seq_ovr_clear;
      ovr_clear && !ovr_set;
   endsequence
   chk_each_load_irq: assert property (tx_load && tx_irq_mode_sel == TXI_EACH |=> tx_irq_o)
      else $error("tx load without interrupt");
   chk_done_irq: assert property (tx_done && tx_count == 3'h0 && !tx_push && tx_irq_mode_sel == TXI_DONE
      |=> tx_irq_o)
      else $error("tx done without interrupt");
   chk_empty_irq: assert property (tx_load && tx_count == 3'h1 && !tx_push && tx_irq_mode_sel == TXI_EMPTY
      |=> tx_irq_o)
      else $error("tx empty without interrupt");
   chk_idle_level: assert property (tx_shift_empty_flag && $stable(tx_idle_polarity) && $stable(infrared_codec_enable)
      |=> serial_tx_o == $past(tx_idle_polarity ^ infrared_codec_enable ^ 1'b1))
      else $error("idle level wrong");
   chk_break_clear: assert property (tx_done && brk_active && !wr_hi |=> !tx_break_request)
      else $error("break request not cleared");
   chk_disable_flush: assert property (tx_flush |=> tx_count == 3'h0 && !tx_busy && !serial_tx_oe_o)
      else $error("disable did not flush");
   chk_full_hold: assert property (tx_buffer_full_flag && !tx_load && !tx_flush |=> tx_count == FIFO_DEPTH)
      else $error("write into full buffer");
   chk_enable_irq: assert property (seq_en_rise |-> ##2 tx_irq_o)
      else $error("enable interrupt not two cycles later");
   chk_rx_full_irq: assert property (rx_push && rx_irq_mode_sel == 2'b11 && rx_next == FIFO_DEPTH
      |=> rx_irq_o)
      else $error("full level interrupt missing");
   chk_ovr_flush: assert property (seq_ovr_clear |=> rx_count == 3'h0 && receiver_idle_flag && !overrun_error_flag)
      else $error("overrun clear did not empty receiver");
   chk_ovr_block: assert property (overrun_error_flag && !rx_pop |=> rx_count == $past(rx_count)
      || rx_count == 3'h0)
      else $error("character taken during overrun");
endmodule
`default_nettype wire

/* File: verification/serial_peer.sv */
// Purpose: remote serial peer on the line, sends built frames and decodes the tx line
// Assumes: 8 data bits lsb first on the tx line, released line reads high
// Notes: frames arrive start bit first, one bit per bit time
`timescale 1ns/1ps
`default_nettype none
module serial_peer
   import uart_sc_pkg::*;
(
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o,
   output logic [7:0] got_o,
   output int frames_o
);
   initial begin
      line_o = 1'b1;
      got_o = 8'h00;
      frames_o = 0;
   end
   // ---------------------------------------------
   // sending
   // ---------------------------------------------
   // one bit per bit time, changed just after an edge
   task automatic send_frame(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         line_o <= bits[i];
         repeat (BIT_CYCLES - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask
   // ---------------------------------------------
   // receiving
   // ---------------------------------------------
   // start seen low, data sampled mid-cell, stop skipped
   always begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
         repeat (BIT_CYCLES / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_i);
            got_o[i] = line_i;
         end
         repeat (BIT_CYCLES) @(posedge clk_i);
         frames_o = frames_o + 1;
      end
   end
endmodule
`default_nettype wire

/* File: verification/uart_status_control_tb.sv */
// Purpose: self-checking bench of the serial status and control block
// Assumes: classic wishbone single cycles, peer model on the serial lines
// Notes: tx line released by the block reads high
`timescale 1ns/1ps
`default_nettype none
module uart_status_control_tb
   import uart_sc_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, tx, oe, tx_irq, rx_irq, rx_line, tx_line, ack;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, q;
   logic [7:0] got;
   int frames, bad_count = 0, tests_run = 0, rx_irqs = 0;
   uart_status_control i_uart_status_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
      .serial_rx_i(rx_line), .serial_tx_o(tx), .serial_tx_oe_o(oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   // released pin pulled high
   assign tx_line = (oe === 1'b1) ? tx : 1'b1;
   serial_peer i_serial_peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line), .got_o(got), .frames_o(frames));
   // ---------------------------------------------
   // clock, watchdog, counters
   // ---------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (80000) @(posedge clk_i);
      bad_count++;
      complete_run();
   end
   always @(posedge clk_i) if (rx_irq === 1'b1) rx_irqs <= rx_irqs + 1;
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic complete_run();
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic irq_at(input int n, input string what);
      repeat (n) @(posedge clk_i);
      chk(what, {31'h0, tx_irq}, 32'h1);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      wb(0, OFS_STATUS, 0, q); chk("status rst", q, 32'h0110);
      wb(0, OFS_MODE, 0, q); chk("mode rst", q, 32'h0);
      wb(0, 4'h2, 0, q); chk("unmapped", q, 32'h0);
   endtask
   task automatic t_tx();
      int n;
      wb(1, OFS_STATUS, 32'h0400, q);
      irq_at(3, "enable irq");
      wb(1, OFS_TX_DATA, 32'ha5, q);
      irq_at(2, "load irq");
      wb(0, OFS_STATUS, 0, q); chk("busy", q, 32'h0410);
      for (n = 0; n < 12000 && frames != 1; n++) @(posedge clk_i);
      chk("tx byte", {24'h0, got}, 32'ha5);
      repeat (BIT_CYCLES) @(posedge clk_i);
      wb(0, OFS_STATUS, 0, q); chk("tx done", q, 32'h0510);
      wb(1, OFS_STATUS, 32'h8400, q);
      wb(1, OFS_TX_DATA, 32'h5a, q);
      irq_at(2, "empty irq");
      wb(1, OFS_STATUS, 32'h2400, q);
      for (n = 0; n < 12000 && tx_irq !== 1'b1; n++) @(posedge clk_i);
      chk("done irq", {31'h0, tx_irq}, 32'h1);
      wb(0, OFS_STATUS, 0, q); chk("done status", q, 32'h2510);
      wb(1, OFS_STATUS, 32'h0400, q);
   endtask
   task automatic t_rx();
      wb(1, OFS_MODE, 32'h1, q);
      i_serial_peer.send_frame({1'b0, 1'b1, 1'b0, 8'h3c, 1'b0}, 11);
      i_serial_peer.send_frame({1'b0, 1'b1, 1'b1, 8'h55, 1'b0}, 11);
      wb(0, OFS_STATUS, 0, q); chk("rx two", q, 32'h0511);
      chk("rx irqs", rx_irqs, 2);
      wb(0, OFS_RX_DATA, 0, q); chk("rx first", {24'h0, q[7:0]}, 32'h3c);
      wb(0, OFS_STATUS, 0, q); chk("rx parity_error_flag", q, 32'h0519);
      wb(0, OFS_RX_DATA, 0, q); chk("rx second", {24'h0, q[7:0]}, 32'h55);
      wb(0, OFS_STATUS, 0, q); chk("rx empty", q, 32'h0510);
   endtask
   task automatic t_pin();
      wb(1, OFS_STATUS, 32'h4400, q);
      repeat (2) @(posedge clk_i); chk("idle pol", {31'h0, tx}, 32'h0);
      wb(1, OFS_MODE, 32'h9, q);
      repeat (2) @(posedge clk_i); chk("idle ir", {31'h0, tx}, 32'h1);
      wb(1, OFS_STATUS, 32'h0, q);
      repeat (2) @(posedge clk_i); chk("pin free", {31'h0, oe}, 32'h0);
   endtask
   task automatic t_full();
      for (int i = 0; i < 4; i++) wb(1, OFS_TX_DATA, 32'h30 + i, q);
      wb(0, OFS_STATUS, 0, q); chk("tx full", q, 32'h0210);
      wb(1, OFS_STATUS, 32'h0400, q);
      wb(1, OFS_STATUS, 32'h0000, q);
      wb(0, OFS_STATUS, 0, q); chk("tx flushed", q, 32'h0110);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; wdat = 32'h0; sel = 4'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_pin();
      t_full();
      complete_run();
   end
endmodule
`default_nettype wire
